// file: rtl/power_mode_controller.sv
// The placing of the registers and the AHB-Lite register port are this design's own decisions.
`timescale 1ns/1ps
`include "power_mode_controller_regs.svh"
// Operation
// - Monitor runs only when enabled, threshold selected.
// - Below flag reports comparison, analog hysteresis.
// - Rising supply above threshold raises line 16.
// - Plain wait instruction enters Sleep immediately.
// - Sleep-on-exit enters Sleep on handler return.
// - Sleep stops only the CPU clock.
// - Sleep wakes on interrupt or event.
// - Event wake from pending interrupt or line.
// - Deep bit with deep select clear enters Deepsleep.
// - Deepsleep regulator mode follows lowpower select.
// - Extra lowpower reduces regulator further.
// - Deepsleep stops core clocks, fast oscillators.
// - Deepsleep wakes on external line by kind.
// - Deepsleep exit waits oscillator, then regulator.
// - Standby powers off regulator and core.
// - Standby tristates pins except exempt ones.
// - Standby exits on wake pin, rtc, reset.
// - Entry flag set on Standby, cleared by write.
// - Wake flag clears two cycles after write.
// - Threshold codes 2.3 to 2.9 V, 000 unused.
// - Voltage codes 00, 10, 11; 01 reserved.
module power_mode_controller
	import power_mode_controller_pkg::*;
#(
	parameter int OSC_CYC = (`OSC_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS,
	parameter int VREG_CYC = (`VREG_SETTLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic reset_n,
	// AHB-Lite slave.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	// Core wait and exception signals.
	input wire logic waitIntr,
	input wire logic waitEvent,
	input wire logic handlerReturn,
	input wire logic periphIrq,
	input wire logic periphPending,
	input wire logic extLineIrq,
	input wire logic extLineEvent,
	// Analog monitor comparator, asynchronous.
	input wire logic monBelowRaw,
	// Standby wakeup sources, asynchronous.
	input wire logic wakePin,
	input wire logic rtcAlarm,
	input wire logic rtcEvent,
	input wire logic extResetPin_n,
	input wire logic watchdogReset,
	// Oscillator ready.
	input wire logic fastOscStable,
	// Power and clock controls.
	output logic cpuClkStop,
	output logic coreClkStop,
	output logic fastOscOff,
	output logic selFastOsc,
	output logic vregLowPower,
	output logic vregExtraLow,
	output logic vregOff,
	output logic [1:0] vregSel,
	output logic [2:0] monThreshold,
	output logic monEnable,
	output logic padsHiZ,
	output logic coreRestart,
	output logic monIrqLine
);
	// Settle counts are loaded into a 16-bit down counter, so they must fit it.
	if (OSC_CYC < 1 || OSC_CYC > 65535 || VREG_CYC < 1 || VREG_CYC > 65535) begin : g_badSettle
		$error("Settle counts must lie between 1 and 65535.");
	end

	// Synchronised asynchronous inputs: three stages, change when 2 and 3 agree.
	logic [4:0] syn1_ff, syn2_ff, syn3_ff, synVal_ff;
	logic [4:0] nxt_synVal;
	logic [4:0] asyncIn;
	assign asyncIn = {monBelowRaw, wakePin, rtcAlarm | rtcEvent, ~extResetPin_n, watchdogReset};

	// Filter accepts a new level only when the last two stages agree.
	always_comb begin
		for (int i = 0; i < 5; i++) begin
			nxt_synVal[i] = (syn2_ff[i] == syn3_ff[i]) ? syn3_ff[i] : synVal_ff[i];
		end
	end

	// Synchroniser stages.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			syn1_ff <= 5'h00;
			syn2_ff <= 5'h00;
			syn3_ff <= 5'h00;
			synVal_ff <= 5'h00;
		end else begin
			syn1_ff <= asyncIn;
			syn2_ff <= syn1_ff;
			syn3_ff <= syn2_ff;
			synVal_ff <= nxt_synVal;
		end
	end

	logic belowS, wakePinS, rtcS, resetS, wdogS;
	assign {belowS, wakePinS, rtcS, resetS, wdogS} = synVal_ff;

	// Bus address phase capture.
	logic dWr_ff, nxt_dWr;
	logic [5:0] dAddr_ff, nxt_dAddr;
	logic busTake;
	assign busTake = hsel && hready && htrans[1];

	// Register state.
	logic monEn_ff, deep_mode_select_ff, deepSel_ff, vregXlp_ff, coreDeep_ff, coreExit_ff, corePend_ff;
	logic [2:0] thr_ff;
	logic [1:0] vsel_ff;
	logic wakeFlag_ff, entryFlag_ff, clrWake_ff, clrWake2_ff, below_ff;
	logic nxt_monEn, nxt_deep_mode_select, nxt_deepSel, nxt_vregXlp, nxt_coreDeep, nxt_coreExit;
	logic nxt_corePend, nxt_wakeFlag, nxt_entryFlag, nxt_clrWake, nxt_clrWake2, nxt_below;
	logic [2:0] nxt_thr;
	logic [1:0] nxt_vsel;
	logic [31:0] nxt_rdata;
	logic enterStandby, standbyWake;
	// Current and next power mode; only the current one is read back through the status register.
	pwr_mode_e mode_ff, nxt_mode;

	// Register file next-state and read mux.
	always_comb begin
		nxt_dWr = busTake && hwrite;
		nxt_dAddr = busTake ? haddr[5:0] : dAddr_ff;
		nxt_monEn = monEn_ff;
		nxt_deep_mode_select = deep_mode_select_ff;
		nxt_deepSel = deepSel_ff;
		nxt_thr = thr_ff;
		nxt_vsel = vsel_ff;
		nxt_vregXlp = vregXlp_ff;
		nxt_coreDeep = coreDeep_ff;
		nxt_coreExit = coreExit_ff;
		nxt_corePend = corePend_ff;
		nxt_clrWake = 1'b0;
		nxt_clrWake2 = clrWake_ff;
		nxt_entryFlag = entryFlag_ff;
		nxt_wakeFlag = wakeFlag_ff;
		// Monitor flag valid only while monitoring is enabled.
		nxt_below = monEn_ff ? belowS : 1'b0;
		if (dWr_ff) begin
			case (dAddr_ff)
				`PMC_CTRL_OFS: begin
					nxt_deep_mode_select = hwdata[`CTRL_DEEP_MODE_SELECT_BIT];
					nxt_deepSel = hwdata[`CTRL_DEEPSEL_BIT];
					nxt_monEn = hwdata[`CTRL_MONEN_BIT];
					// Code 000 is not configurable; keep the old threshold.
					if (hwdata[`CTRL_THR_MSB:`CTRL_THR_LSB] != 3'h0) begin
						nxt_thr = hwdata[`CTRL_THR_MSB:`CTRL_THR_LSB];
					end
					nxt_clrWake = hwdata[`CTRL_CLRWAKE_BIT];
					if (hwdata[`CTRL_CLRENTRY_BIT]) begin
						nxt_entryFlag = 1'b0;
					end
				end
				`PMC_VREG_OFS: begin
					// Reserved voltage code is ignored.
					if (hwdata[`VREG_SEL_MSB:`VREG_SEL_LSB] != `VREG_SEL_RSVD) begin
						nxt_vsel = hwdata[`VREG_SEL_MSB:`VREG_SEL_LSB];
					end
					nxt_vregXlp = hwdata[`VREG_XLP_BIT];
				end
				`PMC_CORE_OFS: begin
					nxt_coreDeep = hwdata[`CORE_DEEP_BIT];
					nxt_coreExit = hwdata[`CORE_EXIT_BIT];
					nxt_corePend = hwdata[`CORE_PEND_BIT];
				end
				default: begin
					// Unmapped writes are ignored.
				end
			endcase
		end
		// Wake flag clears two cycles after the write; set wins.
		if (clrWake2_ff) begin
			nxt_wakeFlag = 1'b0;
		end
		if (standbyWake) begin
			nxt_wakeFlag = 1'b1;
		end
		// Entry sets the flag and wins over a clear.
		if (enterStandby) begin
			nxt_entryFlag = 1'b1;
		end
		// Read data for the next data phase.
		nxt_rdata = 32'h0000_0000;
		if (busTake && !hwrite) begin
			case (haddr[5:0])
				`PMC_CTRL_OFS: begin
					nxt_rdata[`CTRL_DEEP_MODE_SELECT_BIT] = deep_mode_select_ff;
					nxt_rdata[`CTRL_DEEPSEL_BIT] = deepSel_ff;
					nxt_rdata[`CTRL_MONEN_BIT] = monEn_ff;
					nxt_rdata[`CTRL_THR_MSB:`CTRL_THR_LSB] = thr_ff;
				end
				`PMC_STS_OFS: begin
					nxt_rdata[`STS_WAKE_BIT] = wakeFlag_ff;
					nxt_rdata[`STS_ENTRY_BIT] = entryFlag_ff;
					nxt_rdata[`STS_BELOW_BIT] = below_ff;
					nxt_rdata[`STS_MODE_MSB:`STS_MODE_LSB] = mode_ff;
				end
				`PMC_VREG_OFS: begin
					nxt_rdata[`VREG_SEL_MSB:`VREG_SEL_LSB] = vsel_ff;
					nxt_rdata[`VREG_XLP_BIT] = vregXlp_ff;
				end
				`PMC_CORE_OFS: begin
					nxt_rdata[`CORE_DEEP_BIT] = coreDeep_ff;
					nxt_rdata[`CORE_EXIT_BIT] = coreExit_ff;
					nxt_rdata[`CORE_PEND_BIT] = corePend_ff;
				end
				default: begin
					nxt_rdata = 32'h0000_0000;
				end
			endcase
		end else begin
			nxt_rdata = hrdata;
		end
	end

	// Sequencer state.
	logic byEvent_ff, nxt_byEvent, lpDeep_ff, nxt_lpDeep;
	logic [1:0] exitPh_ff, nxt_exitPh;
	logic [15:0] cnt_ff, nxt_cnt;
	logic restart_ff, nxt_restart, prevBelow_ff, irq_ff, nxt_irq;
	logic waitAny, sleepCause, wakeSleep, wakeDeep;
	assign waitAny = waitIntr || waitEvent;
	assign sleepCause = (waitAny && !coreExit_ff) || (coreExit_ff && handlerReturn);
	assign wakeSleep = byEvent_ff ? ((periphPending && corePend_ff) || extLineEvent)
		: periphIrq;
	assign wakeDeep = byEvent_ff ? extLineEvent : extLineIrq;
	assign standbyWake = (mode_ff == MODE_STANDBY)
		&& (wakePinS || rtcS || resetS || wdogS);
	assign enterStandby = (mode_ff == MODE_RUN) && waitAny && coreDeep_ff && deepSel_ff;

	// Mode sequencer next state.
	always_comb begin
		nxt_mode = mode_ff;
		nxt_byEvent = byEvent_ff;
		nxt_lpDeep = lpDeep_ff;
		nxt_exitPh = 2'h0;
		nxt_cnt = cnt_ff;
		nxt_restart = 1'b0;
		case (mode_ff)
			MODE_RUN: begin
				if (coreDeep_ff && waitAny) begin
					nxt_byEvent = waitEvent;
					nxt_lpDeep = deep_mode_select_ff;
					nxt_mode = deepSel_ff ? MODE_STANDBY : MODE_DEEP;
				end else if (!coreDeep_ff && sleepCause) begin
					nxt_byEvent = waitEvent && !coreExit_ff;
					nxt_mode = MODE_SLEEP;
				end
			end
			MODE_SLEEP: begin
				if (wakeSleep) begin
					nxt_mode = MODE_RUN;
				end
			end
			MODE_DEEP: begin
				nxt_exitPh = exitPh_ff;
				if (exitPh_ff == 2'h0 && wakeDeep) begin
					nxt_exitPh = 2'h1;
					nxt_cnt = 16'(OSC_CYC);
				end else if (exitPh_ff == 2'h1 && fastOscStable) begin
					// Oscillator stable; count its settle then regulator if low power.
					if (cnt_ff > 16'h0001) begin
						nxt_cnt = cnt_ff - 16'h0001;
					end else if (lpDeep_ff) begin
						nxt_exitPh = 2'h2;
						nxt_cnt = 16'(VREG_CYC);
					end else begin
						nxt_mode = MODE_RUN;
						nxt_exitPh = 2'h0;
					end
				end else if (exitPh_ff == 2'h2) begin
					if (cnt_ff > 16'h0001) begin
						nxt_cnt = cnt_ff - 16'h0001;
					end else begin
						nxt_mode = MODE_RUN;
						nxt_exitPh = 2'h0;
					end
				end
			end
			MODE_STANDBY: begin
				if (standbyWake) begin
					nxt_mode = MODE_RUN;
					nxt_restart = 1'b1;
				end
			end
			default: begin
				nxt_mode = MODE_RUN;
			end
		endcase
		// Interrupt line pulses when the supply rises above the threshold.
		nxt_irq = monEn_ff && prevBelow_ff && !below_ff;
	end

	// Bus, register file and sequencer state registers.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			dWr_ff <= 1'b0;
			dAddr_ff <= 6'h00;
			hrdata <= 32'h0000_0000;
			monEn_ff <= 1'b0;
			deep_mode_select_ff <= 1'b0;
			deepSel_ff <= 1'b0;
			thr_ff <= 3'h0;
			vsel_ff <= `VREG_SEL_RST;
			vregXlp_ff <= `VREG_XLP_RST;
			coreDeep_ff <= 1'b0;
			coreExit_ff <= 1'b0;
			corePend_ff <= 1'b0;
			wakeFlag_ff <= 1'b0;
			entryFlag_ff <= 1'b0;
			clrWake_ff <= 1'b0;
			clrWake2_ff <= 1'b0;
			below_ff <= 1'b0;
			mode_ff <= MODE_RUN;
			byEvent_ff <= 1'b0;
			lpDeep_ff <= 1'b0;
			exitPh_ff <= 2'h0;
			cnt_ff <= 16'h0000;
			restart_ff <= 1'b0;
			prevBelow_ff <= 1'b0;
			irq_ff <= 1'b0;
		end else begin
			dWr_ff <= nxt_dWr;
			dAddr_ff <= nxt_dAddr;
			hrdata <= nxt_rdata;
			monEn_ff <= nxt_monEn;
			deep_mode_select_ff <= nxt_deep_mode_select;
			deepSel_ff <= nxt_deepSel;
			thr_ff <= nxt_thr;
			vsel_ff <= nxt_vsel;
			vregXlp_ff <= nxt_vregXlp;
			coreDeep_ff <= nxt_coreDeep;
			coreExit_ff <= nxt_coreExit;
			corePend_ff <= nxt_corePend;
			wakeFlag_ff <= nxt_wakeFlag;
			entryFlag_ff <= nxt_entryFlag;
			clrWake_ff <= nxt_clrWake;
			clrWake2_ff <= nxt_clrWake2;
			below_ff <= nxt_below;
			mode_ff <= nxt_mode;
			byEvent_ff <= nxt_byEvent;
			lpDeep_ff <= nxt_lpDeep;
			exitPh_ff <= nxt_exitPh;
			cnt_ff <= nxt_cnt;
			restart_ff <= nxt_restart;
			prevBelow_ff <= below_ff;
			irq_ff <= nxt_irq;
		end
	end

	// Power control outputs, each registered.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			cpuClkStop <= 1'b0;
			coreClkStop <= 1'b0;
			fastOscOff <= 1'b0;
			selFastOsc <= 1'b0;
			vregLowPower <= 1'b0;
			vregExtraLow <= 1'b0;
			vregOff <= 1'b0;
			padsHiZ <= 1'b0;
		end else begin
			cpuClkStop <= nxt_mode != MODE_RUN;
			coreClkStop <= (nxt_mode == MODE_DEEP && nxt_exitPh == 2'h0)
				|| nxt_mode == MODE_STANDBY;
			fastOscOff <= (nxt_mode == MODE_DEEP && nxt_exitPh == 2'h0)
				|| nxt_mode == MODE_STANDBY;
			selFastOsc <= (mode_ff == MODE_DEEP && nxt_mode == MODE_RUN) ? 1'b1
				: (mode_ff == MODE_RUN ? 1'b0 : selFastOsc);
			vregLowPower <= nxt_mode == MODE_DEEP && nxt_lpDeep && nxt_exitPh != 2'h2;
			vregExtraLow <= nxt_mode == MODE_DEEP && nxt_lpDeep && vregXlp_ff
				&& nxt_exitPh != 2'h2;
			vregOff <= nxt_mode == MODE_STANDBY;
			padsHiZ <= nxt_mode == MODE_STANDBY;
		end
	end

	// Bus answers with zero wait states and always OKAY.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign vregSel = vsel_ff;
	assign monThreshold = thr_ff;
	assign monEnable = monEn_ff;
	assign coreRestart = restart_ff;
	assign monIrqLine = irq_ff;
endmodule

// file: rtl/power_mode_controller_regs.svh
`ifndef POWER_MODE_CONTROLLER_REGS_SVH
`define POWER_MODE_CONTROLLER_REGS_SVH
// Register byte offsets.
`define PMC_CTRL_OFS 6'h00
`define PMC_STS_OFS 6'h04
`define PMC_VREG_OFS 6'h10
`define PMC_CORE_OFS 6'h14
// Control register fields.
`define CTRL_DEEPSEL_BIT 1
`define CTRL_DEEP_MODE_SELECT_BIT 0
`define CTRL_CLRWAKE_BIT 2
`define CTRL_CLRENTRY_BIT 3
`define CTRL_MONEN_BIT 4
`define CTRL_THR_LSB 5
`define CTRL_THR_MSB 7
// Status register fields.
`define STS_WAKE_BIT 0
`define STS_ENTRY_BIT 1
`define STS_BELOW_BIT 2
`define STS_MODE_LSB 4
`define STS_MODE_MSB 5
// Regulator register fields and reset values.
`define VREG_SEL_LSB 0
`define VREG_SEL_MSB 1
`define VREG_XLP_BIT 4
`define VREG_SEL_RST 2'h2
`define VREG_XLP_RST 1'h1
`define VREG_SEL_RSVD 2'h1
// Core control register fields.
`define CORE_DEEP_BIT 0
`define CORE_EXIT_BIT 1
`define CORE_PEND_BIT 2
// Timing in nanoseconds or cycles, and system clock period.
`define CLK_PERIOD_NS 5
`define WAKECLR_CYC 2
`define OSC_SETTLE_NS 1000
`define VREG_SETTLE_NS 5000
`endif

// file: rtl/power_mode_controller_pkg.sv
package power_mode_controller_pkg;
	// Power modes of the sequencer.
	typedef enum logic [1:0] {MODE_RUN, MODE_SLEEP, MODE_DEEP, MODE_STANDBY} pwr_mode_e;
endpackage

// file: verification/power_mode_controller_monitor.sv
`timescale 1ns/1ps
module power_mode_controller_monitor (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic reset_n,
	// Watched ports.
	input wire logic waitEvent,
	input wire logic cpuClkStop,
	input wire logic coreClkStop,
	input wire logic fastOscOff,
	input wire logic vregOff,
	input wire logic padsHiZ,
	input wire logic vregLowPower,
	input wire logic vregExtraLow,
	input wire logic [1:0] vregSel,
	input wire logic coreRestart,
	input wire logic monIrqLine,
	input wire logic monEnable
);
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!reset_n);
	// A wait for event in Run with sleep-on-exit clear stops the CPU clock one cycle later.
	a_wfe_enters_sleep: assert property (waitEvent && !cpuClkStop |=> cpuClkStop)
		else $error("wait for event left the cpu clock running");
	// Plain sleep leaves oscillators, regulator and pads alone.
	a_sleep_keeps_rest: assert property ($rose(cpuClkStop) && !coreClkStop |->
		!fastOscOff && !vregOff && !padsHiZ) else $error("sleep touched more than the cpu clock");
	// Stopping the core clocks also turns the fast oscillators off.
	a_deep_osc_off: assert property ($rose(coreClkStop) |-> fastOscOff)
		else $error("deep sleep kept the fast oscillator on");
	// Low-power regulator mode exists only while the CPU is halted; it stays on
	// through the oscillator phase of a deep sleep exit, after core clocks resume.
	a_lowpower_in_deep: assert property (!cpuClkStop |-> !vregLowPower)
		else $error("regulator low power outside deep sleep");
	// Extra low power only on top of low power.
	a_extra_needs_lp: assert property (vregExtraLow |-> vregLowPower)
		else $error("extra low power without low power");
	// Regulator off implies pads released and oscillators off.
	a_standby_all_off: assert property (vregOff |-> padsHiZ && fastOscOff)
		else $error("standby left pads or oscillators active");
	// Restart is a single pulse with the regulator back on.
	a_restart_pulse: assert property (coreRestart |=> !coreRestart && !vregOff)
		else $error("restart pulse malformed");
	// Monitor interrupt is a single pulse while monitoring.
	a_mon_irq_pulse: assert property (monIrqLine |-> monEnable ##1 !monIrqLine)
		else $error("monitor interrupt malformed");
	// The reserved voltage code never reaches the regulator.
	a_vsel_legal: assert property (vregSel != 2'h1)
		else $error("reserved regulator voltage code");
	c_sleep: cover property ($rose(cpuClkStop));
	c_standby: cover property ($rose(vregOff));
	c_restart: cover property (coreRestart);
endmodule

bind power_mode_controller power_mode_controller_monitor power_mode_controller_monitor_i (
	.sys_clk(sys_clk), .reset_n(reset_n), .waitEvent(waitEvent), .cpuClkStop(cpuClkStop),
	.coreClkStop(coreClkStop), .fastOscOff(fastOscOff), .vregOff(vregOff), .padsHiZ(padsHiZ),
	.vregLowPower(vregLowPower), .vregExtraLow(vregExtraLow), .vregSel(vregSel),
	.coreRestart(coreRestart), .monIrqLine(monIrqLine), .monEnable(monEnable)
);

// file: verification/core_model.sv
`timescale 1ns/1ps
module core_model (
	// Clock and reset.
	input wire logic sys_clk,
	input wire logic reset_n,
	// Oscillator shutdown from the sequencer.
	input wire logic fastOscOff,
	// Core instruction strobes.
	output logic waitIntr,
	output logic waitEvent,
	output logic handlerReturn,
	// Oscillator ready.
	output logic fastOscStable
);
	logic [1:0] oscCnt_ff; // Settling counter.
	initial begin
		waitIntr = 1'b0;
		waitEvent = 1'b0;
		handlerReturn = 1'b0;
	end
	// One-cycle strobes, driven just after an edge.
	task automatic wfi();
		waitIntr <= 1'b1;
		@(posedge sys_clk);
		waitIntr <= 1'b0;
	endtask
	task automatic wfe();
		waitEvent <= 1'b1;
		@(posedge sys_clk);
		waitEvent <= 1'b0;
	endtask
	task automatic ret();
		handlerReturn <= 1'b1;
		@(posedge sys_clk);
		handlerReturn <= 1'b0;
	endtask
	// Oscillator settles two cycles after enable and drops at once when off.
	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			oscCnt_ff <= 2'h0;
		end else if (fastOscOff) begin
			oscCnt_ff <= 2'h0;
		end else if (oscCnt_ff != 2'h2) begin
			oscCnt_ff <= oscCnt_ff + 2'h1;
		end
	end
	assign fastOscStable = (oscCnt_ff == 2'h2) && !fastOscOff;
endmodule

// file: verification/tb_top.sv
`timescale 1ns/1ps
`include "power_mode_controller_regs.svh"
module tb_top;
	logic sys_clk = 1'b0;
	logic reset_n = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic [31:0] hrdata, q;
	logic hreadyout, waitIntr, waitEvent, handlerReturn, fastOscStable;
	logic periphIrq = 1'b0;
	logic periphPending = 1'b0;
	logic extLineIrq = 1'b0;
	logic extLineEvent = 1'b0;
	logic monBelowRaw = 1'b0;
	logic [4:0] src = 5'h0; // Standby wake sources.
	logic cpuClkStop, coreClkStop, fastOscOff, selFastOsc, vregLowPower, vregExtraLow, vregOff;
	logic [1:0] vregSel;
	logic [2:0] monThreshold;
	logic monEnable, padsHiZ, coreRestart, monIrqLine;
	int fails = 0;
	int checks_done = 0;
	int n;
	initial forever #2.5 sys_clk = ~sys_clk;
	power_mode_controller #(.OSC_CYC(2), .VREG_CYC(3)) power_mode_controller_i (
		.sys_clk(sys_clk), .reset_n(reset_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
		.hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(), .waitIntr(waitIntr), .waitEvent(waitEvent),
		.handlerReturn(handlerReturn), .periphIrq(periphIrq), .periphPending(periphPending),
		.extLineIrq(extLineIrq), .extLineEvent(extLineEvent), .monBelowRaw(monBelowRaw),
		.wakePin(src[0]), .rtcAlarm(src[1]), .rtcEvent(src[2]), .extResetPin_n(~src[3]),
		.watchdogReset(src[4]), .fastOscStable(fastOscStable), .cpuClkStop(cpuClkStop),
		.coreClkStop(coreClkStop), .fastOscOff(fastOscOff), .selFastOsc(selFastOsc),
		.vregLowPower(vregLowPower), .vregExtraLow(vregExtraLow), .vregOff(vregOff),
		.vregSel(vregSel), .monThreshold(monThreshold), .monEnable(monEnable),
		.padsHiZ(padsHiZ), .coreRestart(coreRestart), .monIrqLine(monIrqLine));
	core_model core_model_i (.sys_clk(sys_clk), .reset_n(reset_n), .fastOscOff(fastOscOff),
		.waitIntr(waitIntr), .waitEvent(waitEvent), .handlerReturn(handlerReturn),
		.fastOscStable(fastOscStable));
	task automatic wrap_up();
		if (fails == 0 && checks_done > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			fails++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Picks an output to wait on.
	function automatic logic sel(input int k);
		case (k)
			0: return cpuClkStop;
			1: return coreRestart;
			2: return monIrqLine;
			3: return vregOff;
			default: return hreadyout;
		endcase
	endfunction
	// Bounded wait for a level; running out ends the run.
	task automatic waitFor(input int k, input logic v, input int lim);
		n = 0;
		while (sel(k) !== v && n < lim) begin
			@(posedge sys_clk);
			n++;
		end
		chk($sformatf("wait %0d", k), 32'(sel(k)), 32'(v));
		if (sel(k) !== v)
			wrap_up();
	endtask
	// One single word transfer: address phase, then data phase.
	task automatic bus(input logic [5:0] a, input logic w, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {26'h0, a};
		hwrite <= w;
		htrans <= 2'h2;
		@(posedge sys_clk);
		waitFor(4, 1'b1, 50);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= d;
		@(posedge sys_clk);
		waitFor(4, 1'b1, 50);
		q = hrdata;
	endtask
	task automatic wr(input logic [5:0] a, input logic [31:0] d);
		bus(a, 1'b1, d);
	endtask
	task automatic rd(input logic [5:0] a, input logic [31:0] e);
		bus(a, 1'b0, 32'h0);
		chk($sformatf("reg %h", a), q, e);
	endtask
	initial begin
		repeat (20) @(posedge sys_clk);
		reset_n <= 1'b1;
		// Reset values, an unmapped word, the reserved voltage code.
		rd(`PMC_CTRL_OFS, 32'h0);
		rd(`PMC_STS_OFS, 32'h0);
		rd(6'h08, 32'h0);
		rd(`PMC_VREG_OFS, 32'h12);
		wr(`PMC_VREG_OFS, 32'h11);
		rd(`PMC_VREG_OFS, 32'h12);
		wr(`PMC_VREG_OFS, 32'h10);
		rd(`PMC_VREG_OFS, 32'h10);
		chk("vregSel", 32'(vregSel), 32'h0);
		// Monitor at 2.5 V: flag, rising interrupt, forced off when disabled.
		wr(`PMC_CTRL_OFS, 32'h70);
		rd(`PMC_CTRL_OFS, 32'h70);
		chk("monitor", 32'({monEnable, monThreshold}), 32'hB);
		monBelowRaw <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rd(`PMC_STS_OFS, 32'h4);
		monBelowRaw <= 1'b0;
		waitFor(2, 1'b1, 10);
		wr(`PMC_CTRL_OFS, 32'h0);
		monBelowRaw <= 1'b1;
		repeat (6) @(posedge sys_clk);
		rd(`PMC_STS_OFS, 32'h0);
		monBelowRaw <= 1'b0;
		// Sleep by each wait kind, left by its own wake source.
		for (int k = 0; k < 3; k++) begin
			wr(`PMC_CORE_OFS, (k == 2) ? 32'h4 : 32'h0);
			if (k == 1)
				core_model_i.wfi();
			else
				core_model_i.wfe();
			waitFor(0, 1'b1, 4);
			rd(`PMC_STS_OFS, 32'h10);
			chk("coreClkStop", 32'(coreClkStop), 32'h0);
			extLineEvent <= (k == 0);
			periphIrq <= (k == 1);
			periphPending <= (k == 2);
			waitFor(0, 1'b0, 10);
			{extLineEvent, periphIrq, periphPending} <= 3'h0;
		end
		// Sleep on exit waits for the handler return.
		wr(`PMC_CORE_OFS, 32'h2);
		core_model_i.wfi();
		repeat (3) @(posedge sys_clk);
		chk("cpuClkStop", 32'(cpuClkStop), 32'h0);
		core_model_i.ret();
		waitFor(0, 1'b1, 4);
		periphIrq <= 1'b1;
		waitFor(0, 1'b0, 10);
		periphIrq <= 1'b0;
		// Low-power deep sleep, woken by an external interrupt line.
		wr(`PMC_CTRL_OFS, 32'h1);
		wr(`PMC_CORE_OFS, 32'h1);
		core_model_i.wfi();
		waitFor(0, 1'b1, 4);
		rd(`PMC_STS_OFS, 32'h20);
		chk("deep", 32'({coreClkStop, fastOscOff, vregLowPower, vregExtraLow}), 32'hF);
		extLineIrq <= 1'b1;
		@(posedge sys_clk);
		extLineIrq <= 1'b0;
		waitFor(0, 1'b0, 40);
		chk("wake time", 32'(n >= 5), 32'h1);
		chk("selFastOsc", 32'(selFastOsc), 32'h1);
		// Software raises the regulator voltage again after selFastOsc has already dropped.
		wr(`PMC_VREG_OFS, 32'h12);
		// Standby left through each wake source in turn.
		for (int k = 0; k < 5; k++) begin
			wr(`PMC_CTRL_OFS, 32'hE);
			wr(`PMC_CORE_OFS, 32'h1);
			core_model_i.wfe();
			waitFor(3, 1'b1, 6);
			rd(`PMC_STS_OFS, 32'h32);
			src[k] <= 1'b1;
			waitFor(1, 1'b1, 20);
			src[k] <= 1'b0;
			rd(`PMC_STS_OFS, 32'h3);
		end
		// Entry flag clears at once; the wake flag only two cycles after the write.
		wr(`PMC_CTRL_OFS, 32'hC);
		rd(`PMC_STS_OFS, 32'h1);
		rd(`PMC_STS_OFS, 32'h0);
		// Clear bits read zero; threshold code 000 was never taken, 2.5 V remains.
		rd(`PMC_CTRL_OFS, 32'h60);
		wrap_up();
	end
endmodule
